// ===== logic/madc_serial_ctrl.sv
// conversion cycle control and serial interface of the adc
//
// Notes on behaviour
// - busy high while converting, low when done, through sleep and output
// - busy rises again when the data output state ends
// - clock select low means host clock, high means device clock
// - device drives serial clock during data output in internal mode; input in external mode
// - internal mode uses busy low as the output framing signal
// - host shifts config word in during output; selects next conversion
// - after reset: channel pair 0/1, paired reference, ratio 256, 1x
// - enable bit low keeps previous speed and channel, ignores the rest
// - first conversion after a change is valid; no discarded conversions
// - one config bit selects the global reference instead of paired one
// - inputs single-ended or differential; common input is negative leg
// - frequency pin tied high or low selects internal oscillator
// - chip select low enables data output and wakes the converter
// - after conversion, sleep while chip select stays high
// - chip select rising during output aborts and starts a conversion
// - data output is high impedance while chip select is high
// - chip select low in convert or sleep: output shows busy status
// - input beyond half reference gives distinct over and under codes
// - frames are 32 bits; output ends after the 32nd bit
// - output data changes on falling serial clock edge
// - external clock on frequency pin drives the conversion clock
`timescale 1ns/100ps
module madc_serial_ctrl #(
    parameter int RESULT_W = madc_pkg::RESULT_BITS,
    parameter int INT_OSC_DIV = 10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // pins
    input wire logic chipSelN,
    input wire logic serDataIn,
    input wire logic clockSourceSelect,
    input wire logic conversionClockControl,
    input wire logic serClkIn,
    output logic serClkOut,
    output logic serClkOe,
    output logic serDataOut,
    output logic serDataOe,
    output logic busy,
    // converter core side
    input wire logic [RESULT_W-1:0] convResult,
    input wire logic overRange,
    input wire logic underRange,
    output logic convStart,
    output logic [2:0] analogInputChannels,
    output logic singleEnded,
    output logic globalRefSel,
    output logic [1:0] oversamplingRatio,
    output logic twoxMode,
    output logic extConvClk
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [1:0] csS;
        logic [1:0] sdiS;
        logic [1:0] extS;
        logic [1:0] f0S;
        logic [1:0] sckS;
        logic f0Prev;
        logic sckPrev;
        logic csPrev;
        logic [7:0] f0Idle;
        logic [7:0] oscDiv;
        logic convTick;
        logic [21:0] convCnt;
        madc_pkg::madc_state_t st;
        logic [31:0] shreg;
        logic [5:0] bitCnt;
        logic [7:0] cfg;
        logic [7:0] halfCnt;
        logic iSck;
        logic [2:0] ch;
        logic sgl;
        logic gref;
        logic [1:0] oversampling_ratio;
        logic twox;
        logic sck;
        logic sckOe;
        logic sdo;
        logic sdoOe;
        logic busy;
        logic start;
        logic extClk;
    } madc_regs_t;

    madc_regs_t r_q;
    madc_regs_t r_d;

    logic [21:0] convLen;
    logic [15:0] osrVal;
    logic sckRise;
    logic sckFall;
    logic csRise;
    logic extMode;
    logic csLow;

    always_comb begin
        osrVal = 16'h0100 << r_q.oversampling_ratio;
        convLen = 22'(madc_pkg::CONV_MUL * osrVal + madc_pkg::CONV_ADD);
    end

    always_comb begin
        r_d = r_q;
        // ********************************************************
        // synchronisers and edges
        // ********************************************************
        r_d.csS = {r_q.csS[0], chipSelN};
        r_d.sdiS = {r_q.sdiS[0], serDataIn};
        r_d.extS = {r_q.extS[0], clockSourceSelect};
        r_d.f0S = {r_q.f0S[0], conversionClockControl};
        r_d.sckS = {r_q.sckS[0], serClkIn};
        r_d.f0Prev = r_q.f0S[1];
        r_d.sckPrev = r_q.sckS[1];
        r_d.csPrev = r_q.csS[1];
        csLow = !r_q.csS[1];
        csRise = r_q.csS[1] && !r_q.csPrev;
        extMode = r_q.extS[1];
        r_d.start = 1'b0;
        // ********************************************************
        // conversion clock source
        // ********************************************************
        r_d.convTick = 1'b0;
        if (r_q.f0S[1] != r_q.f0Prev) begin
            r_d.f0Idle = 8'(madc_pkg::F0_IDLE_CYC);
            if (r_q.f0S[1]) begin
                r_d.convTick = 1'b1;
            end
        end else if (r_q.f0Idle != 8'h00) begin
            r_d.f0Idle = r_q.f0Idle - 8'h01;
        end
        if (r_q.f0Idle == 8'h00) begin
            // static level on the pin: internal oscillator
            r_d.oscDiv = r_q.oscDiv + 8'h01;
            if (r_q.oscDiv == 8'(INT_OSC_DIV - 1)) begin
                r_d.oscDiv = 8'h00;
                r_d.convTick = 1'b1;
            end
        end
        // ********************************************************
        // serial clock edges, from the host pin or the internal clock
        // ********************************************************
        sckRise = 1'b0;
        sckFall = 1'b0;
        if (!extMode) begin
            sckRise = r_q.sckS[1] && !r_q.sckPrev;
            sckFall = !r_q.sckS[1] && r_q.sckPrev;
        end else if (r_q.st == madc_pkg::ST_DOUT) begin
            if (r_q.halfCnt == 8'(madc_pkg::ISCK_HALF_CYC - 1)) begin
                r_d.halfCnt = 8'h00;
                r_d.iSck = !r_q.iSck;
                sckRise = !r_q.iSck;
                sckFall = r_q.iSck;
            end else begin
                r_d.halfCnt = r_q.halfCnt + 8'h01;
            end
        end
        // ********************************************************
        // cycle state machine
        // ********************************************************
        case (r_q.st)
            madc_pkg::ST_CONV: begin
                r_d.busy = 1'b1;
                if (r_q.convTick) begin
                    r_d.convCnt = r_q.convCnt + 22'h1;
                end
                if (r_q.convCnt >= convLen) begin
                    r_d.st = madc_pkg::ST_SLEEP;
                    r_d.busy = 1'b0;
                    if (overRange) begin
                        r_d.shreg = {madc_pkg::OVR_CODE, 28'h0};
                    end else if (underRange) begin
                        r_d.shreg = {madc_pkg::UNR_CODE, 28'h0};
                    end else begin
                        r_d.shreg = 32'(convResult);
                    end
                    r_d.shreg[31] = 1'b0;
                end
            end
            madc_pkg::ST_SLEEP: begin
                if (csLow) begin
                    r_d.st = madc_pkg::ST_DOUT;
                    r_d.bitCnt = 6'h00;
                    r_d.halfCnt = 8'h00;
                    r_d.iSck = 1'b0;
                end
            end
            default: begin
                if (sckRise) begin
                    r_d.cfg = {r_q.cfg[6:0], r_q.sdiS[1]};
                end
                if (sckFall) begin
                    r_d.shreg = {r_q.shreg[30:0], 1'b0};
                    r_d.bitCnt = r_q.bitCnt + 6'h01;
                end
                if (csRise || r_q.bitCnt == 6'(madc_pkg::FRAME_BITS)) begin
                    r_d.st = madc_pkg::ST_CONV;
                    r_d.busy = 1'b1;
                    r_d.convCnt = 22'h0;
                    r_d.start = 1'b1;
                    r_d.iSck = 1'b0;
                    if (r_q.cfg[madc_pkg::CFG_EN_POS]) begin
                        r_d.ch = r_q.cfg[madc_pkg::CFG_CH_LSB +: 3];
                        r_d.sgl = r_q.cfg[madc_pkg::CFG_SGL_POS];
                        r_d.gref = r_q.cfg[madc_pkg::CFG_GREF_POS];
                        r_d.oversampling_ratio = r_q.cfg[madc_pkg::CFG_OSR_LSB +: 2];
                    end
                    r_d.cfg = 8'h00;
                end
            end
        endcase
        // ********************************************************
        // pins
        // ********************************************************
        r_d.sck = r_d.iSck;
        r_d.sckOe = extMode && r_d.st == madc_pkg::ST_DOUT;
        r_d.sdoOe = !r_q.csS[1];
        r_d.extClk = r_d.f0Idle != 8'h00;
        if (r_d.st == madc_pkg::ST_DOUT) begin
            r_d.sdo = r_d.shreg[31];
        end else begin
            r_d.sdo = r_d.busy;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r_q <= '0;
            r_q.csS <= 2'h3;
            r_q.csPrev <= 1'b1;
            r_q.st <= madc_pkg::ST_CONV;
            r_q.busy <= 1'b1;
            r_q.ch <= madc_pkg::CH_RST;
            r_q.oversampling_ratio <= madc_pkg::OSR_RST;
            r_q.sgl <= madc_pkg::SGL_RST;
            r_q.gref <= madc_pkg::GREF_RST;
            r_q.twox <= madc_pkg::TWOX_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb begin
        serClkOut = r_q.sck;
        serClkOe = r_q.sckOe;
        serDataOut = r_q.sdo;
        serDataOe = r_q.sdoOe;
        busy = r_q.busy;
        convStart = r_q.start;
        analogInputChannels = r_q.ch;
        singleEnded = r_q.sgl;
        globalRefSel = r_q.gref;
        oversamplingRatio = r_q.oversampling_ratio;
        twoxMode = r_q.twox;
        extConvClk = r_q.extClk;
    end
endmodule

// ===== common/madc_pkg.sv
// package of constants for the multichannel adc serial control block
package madc_pkg;
    // ************************************************************
    // timing and sizes
    // ************************************************************
    localparam int SYS_CLK_HZ = 20000000;
    localparam int FRAME_BITS = 32;
    localparam int CFG_BITS = 8;
    localparam int RESULT_BITS = 29;
    // internal serial clock, about 0.9 MHz nominal
    localparam int ISCK_HZ = 900000;
    localparam int ISCK_HALF_CYC = SYS_CLK_HZ / (2 * ISCK_HZ);
    // conversion length in conversion clock ticks, 1x mode: 40*OVERSAMPLING_RATIO+178
    localparam int CONV_MUL = 40;
    localparam int CONV_ADD = 178;
    // f0 activity watchdog: edges seen within this many cycles -> external
    localparam int F0_IDLE_CYC = 255;
    // ************************************************************
    // configuration word layout
    // ************************************************************
    localparam int CFG_EN_POS = 7;
    localparam int CFG_SGL_POS = 6;
    localparam int CFG_GREF_POS = 5;
    localparam int CFG_CH_LSB = 2;
    localparam int CFG_OSR_LSB = 0;
    localparam logic [2:0] CH_RST = 3'h0;
    localparam logic [1:0] OSR_RST = 2'h0;
    localparam logic SGL_RST = 1'b0;
    localparam logic GREF_RST = 1'b0;
    localparam logic TWOX_RST = 1'b0;
    // over and under range codes, top four bits of a frame
    localparam logic [3:0] OVR_CODE = 4'h3;
    localparam logic [3:0] UNR_CODE = 4'h0;

    typedef enum logic [1:0] {
        ST_CONV = 2'b00,
        ST_SLEEP = 2'b01,
        ST_DOUT = 2'b10
    } madc_state_t;
endpackage

// ===== tb/madc_serial_ctrl_properties.sv
// checker of the adc serial control block
`timescale 1ns/100ps
module madc_serial_ctrl_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // pins
    input wire logic chipSelN,
    input wire logic serClkIn,
    input wire logic clockSourceSelect,
    input wire logic serClkOe,
    input wire logic serDataOut,
    input wire logic serDataOe,
    input wire logic busy,
    // core side
    input wire logic convStart,
    input wire logic [2:0] analogInputChannels,
    input wire logic twoxMode
);
    logic [7:0] sinceFall;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            sinceFall <= 8'hFF;
        else if ($fell(serClkIn))
            sinceFall <= 8'h00;
        else if (sinceFall != 8'hFF)
            sinceFall <= sinceFall + 8'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sdo_tristate_a: assert property (chipSelN [*4] |-> !serDataOe)
        else $error("sdo driven with cs high");
    conv_status_a: assert property ((busy && !chipSelN) [*6] |->
        serDataOut && serDataOe) else $error("sdo status not high");
    busy_low_a: assert property ($fell(busy) |=> !busy [*8])
        else $error("busy not held low");
    start_busy_a: assert property ($rose(busy) |->
        convStart or $past(convStart) or ##1 convStart)
        else $error("busy rose without start");
    sck_drive_a: assert property (serClkOe |->
        clockSourceSelect && !$past(busy)) else $error("sck driven");
    fall_align_a: assert property (serDataOe && $past(serDataOe) &&
        $changed(serDataOut) && !busy && !$past(busy, 8) &&
        !clockSourceSelect |-> sinceFall < 8'h08)
        else $error("sdo moved off sck fall");
    cfg_apply_a: assert property ($changed(analogInputChannels) |->
        convStart or $past(convStart)) else $error("channel moved");
    onex_mode_a: assert property (!twoxMode)
        else $error("2x mode set");
    sleep_hold_a: assert property ((!busy && chipSelN) [*8] |=>
        !busy) else $error("woke with cs high");
    cover property ($rose(busy));
    cover property (serClkOe);
    cover property (convStart && analogInputChannels != 3'h0);
endmodule

// ===== tb/madc_host.sv
// host side serial model of the adc bench
`timescale 1ns/100ps
module madc_host (
    // clock
    input wire logic sys_clk,
    // serial pins
    output logic chipSelN,
    output logic serClkIn,
    output logic serDataIn,
    input wire logic serDataOut
);
    initial begin
        chipSelN = 1'b1;
        serClkIn = 1'b0;
        serDataIn = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic select();
        chipSelN = 1'b0;
    endtask
    task automatic release_cs();
        chipSelN = 1'b1;
        hold(2);
    endtask
    // n clock pulses, sdo taken late in each high phase
    task automatic frame(input logic [31:0] din, input int n,
            output logic [31:0] word);
        word = 32'h0;
        select();
        for (int i = 31; i > 31 - n; i--) begin
            serDataIn = din[i];
            hold(4);
            serClkIn = 1'b1;
            hold(4);
            word[i] = serDataOut;
            serClkIn = 1'b0;
        end
        hold(2);
        serDataIn = ~serDataIn;
    endtask
endmodule

// ===== tb/madc_serial_ctrl_test.sv
// self-checking bench of the adc serial control block
`timescale 1ns/100ps
module madc_serial_ctrl_test;
    logic sys_clk;
    logic nrst;
    logic clockSourceSelect;
    logic conversionClockControl;
    logic overRange;
    logic underRange;
    logic [28:0] convResult;
    logic chipSelN, serClkIn, serDataIn, serClkOut, serClkOe;
    logic serDataOut, serDataOe, busy, convStart, singleEnded;
    logic globalRefSel, twoxMode, extConvClk;
    logic [2:0] analogInputChannels;
    logic [1:0] oversamplingRatio;
    logic [31:0] word;
    logic f0Run;
    logic sckSeen = 1'b0;
    int n_fail = 0;
    int tests_run = 0;
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (f0Run)
            conversionClockControl <= #1 ~conversionClockControl;
        if (serClkOe)
            sckSeen <= 1'b1;
    end
    madc_serial_ctrl #(.INT_OSC_DIV(1)) u_madc_serial_ctrl (.sys_clk,
        .nrst, .chipSelN, .serDataIn, .clockSourceSelect,
        .conversionClockControl, .serClkIn, .serClkOut, .serClkOe,
        .serDataOut, .serDataOe, .busy, .convResult, .overRange,
        .underRange, .convStart, .analogInputChannels, .singleEnded,
        .globalRefSel, .oversamplingRatio, .twoxMode, .extConvClk);
    madc_host u_madc_host (.sys_clk, .chipSelN, .serClkIn, .serDataIn,
        .serDataOut);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (int k = 0; k < lim && busy !== lvl; k++)
            u_madc_host.hold(1);
    endtask
    // full frame with config byte, then back to convert
    task automatic run_frame(input logic [7:0] cfg);
        wait_busy(1'b0, 12000);
        u_madc_host.frame({24'h0, cfg}, 32, word);
        wait_busy(1'b1, 20);
        check(busy, 1'b1);
        u_madc_host.release_cs();
    endtask
    initial begin
        #4000000;
        n_fail++;
        stop_test();
    end
    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        clockSourceSelect = 1'b0;
        conversionClockControl = 1'b0;
        overRange = 1'b0;
        underRange = 1'b0;
        convResult = 29'h0123456;
        f0Run = 1'b0;
        u_madc_host.hold(16);
        nrst = 1'b1;
        check(analogInputChannels, madc_pkg::CH_RST);
        check(oversamplingRatio, madc_pkg::OSR_RST);
        check({singleEnded, globalRefSel, twoxMode}, 3'h0);
        u_madc_host.select();
        u_madc_host.hold(6);
        check({serDataOe, serDataOut}, 2'h3);
        wait_busy(1'b0, 12000);
        check(busy, 1'b0);
        u_madc_host.hold(2);
        check(serDataOut, 1'b0);
        u_madc_host.release_cs();
        u_madc_host.hold(4);
        check(serDataOe, 1'b0);
        overRange = 1'b1;
        wait_busy(1'b0, 12000);
        u_madc_host.hold(50);
        check(busy, 1'b0);
        run_frame(8'hF4);
        check(word[31:28], madc_pkg::OVR_CODE);
        check(analogInputChannels, 3'h5);
        check({singleEnded, globalRefSel}, 2'h3);
        overRange = 1'b0;
        underRange = 1'b1;
        run_frame(8'h7B);
        check(word[31:28], madc_pkg::UNR_CODE);
        check({analogInputChannels, oversamplingRatio}, 5'h14);
        wait_busy(1'b0, 12000);
        u_madc_host.frame(32'h0, 10, word);
        check(busy, 1'b0);
        u_madc_host.release_cs();
        wait_busy(1'b1, 10);
        check(busy, 1'b1);
        check(sckSeen, 1'b0);
        wait_busy(1'b0, 12000);
        clockSourceSelect = 1'b1;
        u_madc_host.hold(2);
        u_madc_host.select();
        wait_busy(1'b1, 1000);
        check({busy, sckSeen}, 2'h3);
        u_madc_host.release_cs();
        clockSourceSelect = 1'b0;
        f0Run = 1'b1;
        u_madc_host.hold(300);
        check(extConvClk, 1'b1);
        f0Run = 1'b0;
        u_madc_host.hold(600);
        check(extConvClk, 1'b0);
        stop_test();
    end
endmodule
bind madc_serial_ctrl madc_serial_ctrl_properties u_madc_serial_ctrl_properties
    (.sys_clk, .nrst, .chipSelN, .serClkIn, .clockSourceSelect, .serClkOe,
    .serDataOut, .serDataOe, .busy, .convStart, .analogInputChannels,
    .twoxMode);
